/* rtl/acc_pkg.sv */
// Shared constants for the analog comparator control block.
// Assumes byte addressing on a 32-bit Avalon-MM bus, one register per word.
package acc_pkg;

  // ----------------------------------------------------------------
  // Bus and register geometry
  // ----------------------------------------------------------------
  localparam int ACC_ADDR_W = 8;
  localparam int ACC_DATA_W = 32;
  localparam int ACC_REG_W = 8;
  localparam int ACC_IDX_W = 6;
  localparam int ACC_PIN_W = 3;
  localparam int ACC_LEVEL_W = 6;
  localparam int ACC_SEL_W = 2;
  localparam int ACC_ROUTE_W = 3;

  // Register indices; byte address is four times the index
  localparam logic [ACC_IDX_W-1:0] ACC_IDX_CTRL_STATUS = 6'h2C;
  localparam logic [ACC_IDX_W-1:0] ACC_IDX_INPUT_SELECT = 6'h2D;
  localparam logic [ACC_IDX_W-1:0] ACC_IDX_REF_DAC = 6'h2E;
  localparam logic [ACC_IDX_W-1:0] ACC_IDX_INPUT_PIN = 6'h2F;
  localparam logic [1:0] ACC_BYTE_OFS = 2'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACC_CS_ENABLE = 7;
  localparam int ACC_CS_HYS = 6;
  localparam int ACC_CS_FLAG = 5;
  localparam int ACC_CS_IRQ_EN = 4;
  localparam int ACC_CS_RESULT = 3;
  localparam int ACC_CS_OUT_PIN = 2;
  localparam int ACC_CS_SENSE_LO = 0;
  localparam int ACC_POS_SEL_LO = 4;
  localparam int ACC_NEG_SEL_LO = 0;
  localparam int ACC_DAC_ENABLE = 7;
  localparam int ACC_DAC_SOURCE = 6;
  localparam int ACC_DAC_LEVEL_LO = 0;
  localparam int ACC_PIN_LO = 0;

  // Reset values
  localparam logic [ACC_REG_W-1:0] ACC_REG_RESET = 8'h00;
  localparam logic [ACC_DATA_W-1:0] ACC_DATA_ZERO = 32'h0000_0000;

  // Input selector codes
  localparam logic [ACC_SEL_W-1:0] ACC_SEL_EXT0 = 2'h0;
  localparam logic [ACC_SEL_W-1:0] ACC_SEL_EXT1 = 2'h1;
  localparam logic [ACC_SEL_W-1:0] ACC_SEL_RSVD = 2'h2;
  localparam logic [ACC_SEL_W-1:0] ACC_SEL_DAC = 2'h3;
  // Route vector bits: {dac, ext1, ext0}
  localparam int ACC_ROUTE_EXT0 = 0;
  localparam int ACC_ROUTE_EXT1 = 1;
  localparam int ACC_ROUTE_DAC = 2;

  // Edge sense codes
  localparam logic [1:0] ACC_SENSE_FALL_A = 2'h0;
  localparam logic [1:0] ACC_SENSE_RISE = 2'h1;
  localparam logic [1:0] ACC_SENSE_FALL_B = 2'h2;
  localparam logic [1:0] ACC_SENSE_BOTH = 2'h3;

  // Valid-edge decode, shared by the flag and the wake path
  function automatic logic acc_edge_ok(input logic [1:0] sense, input logic rise,
                                       input logic fall);
    logic ok;
    ok = 1'b0;
    unique case (sense)
      ACC_SENSE_FALL_A, ACC_SENSE_FALL_B: ok = fall;
      ACC_SENSE_RISE: ok = rise;
      ACC_SENSE_BOTH: ok = rise | fall;
    endcase
    return ok;
  endfunction

endpackage

/* rtl/acc_edge_if.sv */
// Carrier between the control top and its edge detector.
// Assumes both ends run on mclk.
`timescale 1ns/10ps
`default_nettype none
interface acc_edge_if;
  logic level;
  logic [1:0] sense;
  logic armed;
  logic valid_edge;
  modport det (input level, input sense, input armed, output valid_edge);
  modport ctl (output level, output sense, output armed, input valid_edge);
endinterface
`default_nettype wire

/* rtl/acc_sync3.sv */
// Three-stage synchroniser for the raw comparator output.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module acc_sync3 (
  input wire logic mclk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic s1_r, s2_r, s3_r, out_r;
  logic out_nxt;

  // Accept a change only once stages two and three agree
  always_comb begin
    out_nxt = out_r;
    if (s2_r == s3_r) begin
      out_nxt = s3_r;
    end
  end

  // Stage one is read by stage two only
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;

endmodule
`default_nettype wire

/* rtl/acc_edge.sv */
// Edge detector on the synchronised comparison result.
// Assumes level is already in the mclk domain.
`timescale 1ns/10ps
`default_nettype none
module acc_edge
  import acc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  acc_edge_if.det eif
);

  // ----------------------------------------------------------------
  // Previous sample and pulse
  // ----------------------------------------------------------------
  logic prev_r, prev_nxt;
  logic pulse_r, pulse_nxt;

  // Compare with last sample; one pulse per qualifying transition
  always_comb begin
    prev_nxt = eif.level;
    pulse_nxt = eif.armed &
                acc_edge_ok(eif.sense, eif.level & ~prev_r, ~eif.level & prev_r);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign eif.valid_edge = pulse_r;

endmodule
`default_nettype wire

/* rtl/acc_top.sv */
// Control logic of the analog comparator and its 6-bit reference DAC.
// Assumes an Avalon-MM master on mclk, an analog macro on the analog
// side, and a power controller that flags the deep stop mode.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Reserved bits of input select and pin registers read zero, ignore writes.
// - Positive selector bits 5:4: 00 ext0, 01 ext1, 10 none, 11 DAC.
// - Negative selector uses the same two-bit coding in bits 1:0.
// - DAC control bit 7 enables the reference DAC output.
// - DAC control bit 6 picks bandgap (0) or analog supply (1).
// - Six-bit DAC level goes to the DAC; output is ref/64 times level+1.
// - Three pin-allow bits, one per external input pad.
// - Edge sense: 00 and 10 falling, 01 rising, 11 both.
// - Valid edge sets the flag; interrupt while flag and enable both set.
// - Flag is set only while the bus clock runs.
// - Flag stays set until software writes zero to it.
// - Raw comparator output is synchronised into the readable result bit.
// - Result bit freezes in deep stop and resynchronises on wake.
// - In deep stop a valid edge raises a wake-up request.
// - Reset returns defaults with comparator and DAC disabled.
// - Comparator output reaches the pin only when output pin enable is set.
// - Control/status: 7 enable, 6 hysteresis, 5 flag, 4 irq-enable, 3 result, 2 pin, 1:0 sense.
// - Writing one to the flag does nothing; only zero clears it.
// - Result bit resets to zero and reads zero while comparator is disabled.
module acc_top
  import acc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ACC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ACC_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [ACC_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic raw_compare_out,
  input wire logic deep_stop_mode,
  output logic comparator_enable,
  output logic hysteresis_select,
  output logic [ACC_ROUTE_W-1:0] pos_route,
  output logic [ACC_ROUTE_W-1:0] neg_route,
  output logic ref_dac_enable,
  output logic ref_dac_source,
  output logic [ACC_LEVEL_W-1:0] ref_dac_level,
  output logic [ACC_PIN_W-1:0] ext_input_pin_allow,
  output logic output_pin_enable,
  output logic compare_pin_out,
  output logic edge_irq,
  output logic wake_req
);

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  // Selector code to one-hot analog route; the reserved code routes nothing
  function automatic logic [ACC_ROUTE_W-1:0] sel_route(input logic [ACC_SEL_W-1:0] code);
    logic [ACC_ROUTE_W-1:0] r;
    r = '0;
    unique case (code)
      ACC_SEL_EXT0: r[ACC_ROUTE_EXT0] = 1'b1;
      ACC_SEL_EXT1: r[ACC_ROUTE_EXT1] = 1'b1;
      ACC_SEL_RSVD: r = '0;
      ACC_SEL_DAC: r[ACC_ROUTE_DAC] = 1'b1;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic cs_enable_r, cs_enable_nxt;
  logic cs_hys_r, cs_hys_nxt;
  logic cs_flag_r, cs_flag_nxt;
  logic cs_irq_en_r, cs_irq_en_nxt;
  logic cs_out_pin_r, cs_out_pin_nxt;
  logic [1:0] cs_sense_r, cs_sense_nxt;
  logic [ACC_SEL_W-1:0] pos_sel_r, pos_sel_nxt;
  logic [ACC_SEL_W-1:0] neg_sel_r, neg_sel_nxt;
  logic dac_en_r, dac_en_nxt;
  logic dac_src_r, dac_src_nxt;
  logic [ACC_LEVEL_W-1:0] dac_level_r, dac_level_nxt;
  logic [ACC_PIN_W-1:0] pin_allow_r, pin_allow_nxt;
  logic result_r, result_nxt;

  // Bus state
  logic wait_r, wait_nxt;
  logic [ACC_DATA_W-1:0] rdata_r, rdata_nxt;

  // Output and wake state
  logic [ACC_ROUTE_W-1:0] pos_route_r, pos_route_nxt;
  logic [ACC_ROUTE_W-1:0] neg_route_r, neg_route_nxt;
  logic pin_out_r, pin_out_nxt;
  logic irq_r, irq_nxt;
  logic wake_r, wake_nxt;

  logic sync_level;
  logic [ACC_IDX_W-1:0] idx;
  logic addr_ok;
  logic wr_commit;
  logic [ACC_REG_W-1:0] wbyte;
  logic [ACC_REG_W-1:0] rd_byte;
  logic stop_rise, stop_fall;

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  acc_edge_if eif ();

  acc_sync3 u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(raw_compare_out),
    .sync_out(sync_level)
  );

  acc_edge u_edge (
    .mclk(mclk),
    .rst(rst),
    .eif(eif)
  );

  // Edges are taken from the bus-visible result, which is frozen in stop;
  // not gating on stop keeps an edge that lands just before entry
  assign eif.level = result_r;
  assign eif.sense = cs_sense_r;
  assign eif.armed = cs_enable_r;

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  assign idx = avs_address[ACC_ADDR_W-1:2];
  assign addr_ok = (avs_address[1:0] == ACC_BYTE_OFS) &&
                   (idx == ACC_IDX_CTRL_STATUS || idx == ACC_IDX_INPUT_SELECT ||
                    idx == ACC_IDX_REF_DAC || idx == ACC_IDX_INPUT_PIN);
  // A write lands only at the edge where waitrequest is seen low
  assign wr_commit = avs_write & ~wait_r & avs_byteenable[0] & addr_ok;
  assign wbyte = avs_writedata[ACC_REG_W-1:0];

  // Reserved fields are simply never stored, so they read zero
  always_comb begin
    rd_byte = ACC_REG_RESET;
    unique case (idx)
      ACC_IDX_CTRL_STATUS: begin
        rd_byte[ACC_CS_ENABLE] = cs_enable_r;
        rd_byte[ACC_CS_HYS] = cs_hys_r;
        rd_byte[ACC_CS_FLAG] = cs_flag_r;
        rd_byte[ACC_CS_IRQ_EN] = cs_irq_en_r;
        rd_byte[ACC_CS_RESULT] = result_r & cs_enable_r;
        rd_byte[ACC_CS_OUT_PIN] = cs_out_pin_r;
        rd_byte[ACC_CS_SENSE_LO +: 2] = cs_sense_r;
      end
      ACC_IDX_INPUT_SELECT: begin
        rd_byte[ACC_POS_SEL_LO +: ACC_SEL_W] = pos_sel_r;
        rd_byte[ACC_NEG_SEL_LO +: ACC_SEL_W] = neg_sel_r;
      end
      ACC_IDX_REF_DAC: begin
        rd_byte[ACC_DAC_ENABLE] = dac_en_r;
        rd_byte[ACC_DAC_SOURCE] = dac_src_r;
        rd_byte[ACC_DAC_LEVEL_LO +: ACC_LEVEL_W] = dac_level_r;
      end
      ACC_IDX_INPUT_PIN: begin
        rd_byte[ACC_PIN_LO +: ACC_PIN_W] = pin_allow_r;
      end
      default: rd_byte = ACC_REG_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, then a single low waitrequest
  // ----------------------------------------------------------------
  always_comb begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if ((avs_read | avs_write) && wait_r) begin
      wait_nxt = 1'b0;
      if (avs_read) begin
        rdata_nxt = addr_ok ? {{(ACC_DATA_W-ACC_REG_W){1'b0}}, rd_byte} : ACC_DATA_ZERO;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wait_r <= 1'b1;
      rdata_r <= ACC_DATA_ZERO;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register writes and hardware updates
  // ----------------------------------------------------------------
  always_comb begin
    cs_enable_nxt = cs_enable_r;
    cs_hys_nxt = cs_hys_r;
    cs_irq_en_nxt = cs_irq_en_r;
    cs_out_pin_nxt = cs_out_pin_r;
    cs_sense_nxt = cs_sense_r;
    pos_sel_nxt = pos_sel_r;
    neg_sel_nxt = neg_sel_r;
    dac_en_nxt = dac_en_r;
    dac_src_nxt = dac_src_r;
    dac_level_nxt = dac_level_r;
    pin_allow_nxt = pin_allow_r;
    cs_flag_nxt = cs_flag_r;
    if (wr_commit) begin
      unique case (idx)
        ACC_IDX_CTRL_STATUS: begin
          cs_enable_nxt = wbyte[ACC_CS_ENABLE];
          cs_hys_nxt = wbyte[ACC_CS_HYS];
          cs_irq_en_nxt = wbyte[ACC_CS_IRQ_EN];
          cs_out_pin_nxt = wbyte[ACC_CS_OUT_PIN];
          cs_sense_nxt = wbyte[ACC_CS_SENSE_LO +: 2];
          if (!wbyte[ACC_CS_FLAG]) begin
            cs_flag_nxt = 1'b0;
          end
        end
        ACC_IDX_INPUT_SELECT: begin
          pos_sel_nxt = wbyte[ACC_POS_SEL_LO +: ACC_SEL_W];
          neg_sel_nxt = wbyte[ACC_NEG_SEL_LO +: ACC_SEL_W];
        end
        ACC_IDX_REF_DAC: begin
          dac_en_nxt = wbyte[ACC_DAC_ENABLE];
          dac_src_nxt = wbyte[ACC_DAC_SOURCE];
          dac_level_nxt = wbyte[ACC_DAC_LEVEL_LO +: ACC_LEVEL_W];
        end
        ACC_IDX_INPUT_PIN: begin
          pin_allow_nxt = wbyte[ACC_PIN_LO +: ACC_PIN_W];
        end
        default: cs_flag_nxt = cs_flag_r;
      endcase
    end
    // A valid edge in the clearing cycle wins, so no event is lost
    if (eif.valid_edge) begin
      cs_flag_nxt = 1'b1;
    end
  end

  // Result follows the comparator while enabled and awake
  always_comb begin
    result_nxt = result_r;
    if (!cs_enable_r) begin
      result_nxt = 1'b0;
    end else if (!deep_stop_mode) begin
      result_nxt = sync_level;
    end
  end

  // Reset leaves comparator and DAC disabled
  always_ff @(posedge mclk) begin
    if (rst) begin
      cs_enable_r <= 1'b0;
      cs_hys_r <= 1'b0;
      cs_flag_r <= 1'b0;
      cs_irq_en_r <= 1'b0;
      cs_out_pin_r <= 1'b0;
      cs_sense_r <= ACC_SENSE_FALL_A;
      pos_sel_r <= ACC_SEL_EXT0;
      neg_sel_r <= ACC_SEL_EXT0;
      dac_en_r <= 1'b0;
      dac_src_r <= 1'b0;
      dac_level_r <= '0;
      pin_allow_r <= '0;
      result_r <= 1'b0;
    end else begin
      cs_enable_r <= cs_enable_nxt;
      cs_hys_r <= cs_hys_nxt;
      cs_flag_r <= cs_flag_nxt;
      cs_irq_en_r <= cs_irq_en_nxt;
      cs_out_pin_r <= cs_out_pin_nxt;
      cs_sense_r <= cs_sense_nxt;
      pos_sel_r <= pos_sel_nxt;
      neg_sel_r <= neg_sel_nxt;
      dac_en_r <= dac_en_nxt;
      dac_src_r <= dac_src_nxt;
      dac_level_r <= dac_level_nxt;
      pin_allow_r <= pin_allow_nxt;
      result_r <= result_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Analog controls, pin output, interrupt and wake
  // ----------------------------------------------------------------
  // Wake compares the live synchronised level with the frozen result; the
  // result catches up on exit, and that late edge then sets the flag
  assign stop_rise = sync_level & ~result_r;
  assign stop_fall = ~sync_level & result_r;

  always_comb begin
    pos_route_nxt = sel_route(pos_sel_r);
    neg_route_nxt = sel_route(neg_sel_r);
    pin_out_nxt = cs_out_pin_r & result_r;
    irq_nxt = cs_flag_r & cs_irq_en_r;
    wake_nxt = wake_r;
    if (!deep_stop_mode) begin
      wake_nxt = 1'b0;
    end else if (cs_enable_r && acc_edge_ok(cs_sense_r, stop_rise, stop_fall)) begin
      wake_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pos_route_r <= '0;
      neg_route_r <= '0;
      pin_out_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      pos_route_r <= pos_route_nxt;
      neg_route_r <= neg_route_nxt;
      pin_out_r <= pin_out_nxt;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign comparator_enable = cs_enable_r;
  assign hysteresis_select = cs_hys_r;
  assign pos_route = pos_route_r;
  assign neg_route = neg_route_r;
  assign ref_dac_enable = dac_en_r;
  assign ref_dac_source = dac_src_r;
  assign ref_dac_level = dac_level_r;
  assign ext_input_pin_allow = pin_allow_r;
  assign output_pin_enable = cs_out_pin_r;
  assign compare_pin_out = pin_out_r;
  assign edge_irq = irq_r;
  assign wake_req = wake_r;

endmodule
`default_nettype wire

/* verif/acc_top_assertions.sv */
// Checker for the comparator control top: bus handshake and register effects.
// Assumes it is bound to acc_top on one mclk domain with synchronous rst.
`timescale 1ns/10ps
`default_nettype none
module acc_top_chk
  import acc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ACC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ACC_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [ACC_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic deep_stop_mode,
  input wire logic comparator_enable,
  input wire logic hysteresis_select,
  input wire logic [ACC_ROUTE_W-1:0] pos_route,
  input wire logic [ACC_ROUTE_W-1:0] neg_route,
  input wire logic ref_dac_enable,
  input wire logic ref_dac_source,
  input wire logic [ACC_LEVEL_W-1:0] ref_dac_level,
  input wire logic output_pin_enable,
  input wire logic compare_pin_out,
  input wire logic edge_irq,
  input wire logic wake_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic wr_done;
  logic rd_done;
  // Completed accesses; a write without lane 0 changes nothing
  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_done = avs_read && !avs_waitrequest;
  function automatic logic [2:0] route_of(input logic [1:0] c);
    return (c == 2'h3) ? 3'h4 : (c == 2'h2) ? 3'h0 : (c == 2'h1) ? 3'h2 : 3'h1;
  endfunction
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop one cycle after a request");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rsvd_select: assert property (rd_done && avs_address == 8'hB4 |->
    avs_readdata[31:6] == 26'h0 && avs_readdata[3:2] == 2'h0)
    else $error("reserved selector bits read nonzero");
  a_rsvd_pins: assert property (rd_done && avs_address == 8'hBC |->
    avs_readdata[31:3] == 29'h0)
    else $error("reserved pin bits read nonzero");
  a_route_set: assert property (wr_done && avs_address == 8'hB4 |-> ##2
    pos_route == route_of($past(avs_writedata[5:4], 2))
    && neg_route == route_of($past(avs_writedata[1:0], 2)))
    else $error("route does not match selector code");
  a_dac_set: assert property (wr_done && avs_address == 8'hB8 |=>
    {ref_dac_enable, ref_dac_source, ref_dac_level} == $past(avs_writedata[7:0]))
    else $error("DAC outputs do not match written value");
  a_ctrl_set: assert property (wr_done && avs_address == 8'hB0 |=>
    comparator_enable == $past(avs_writedata[7]) && hysteresis_select == $past(avs_writedata[6])
    && output_pin_enable == $past(avs_writedata[2]))
    else $error("control outputs do not match written value");
  a_pin_gate: assert property (compare_pin_out |-> $past(output_pin_enable))
    else $error("comparator pin driven without pin enable");
  a_irq_sticky: assert property (edge_irq && !wr_done && !$past(wr_done) |=> edge_irq)
    else $error("interrupt dropped without a write");
  a_result_off: assert property (rd_done && avs_address == 8'hB0 && !comparator_enable
    |-> !avs_readdata[3])
    else $error("result reads one while disabled");
  a_wake_stop: assert property ($rose(wake_req) |-> $past(deep_stop_mode))
    else $error("wake request outside deep stop");
  a_wake_exit: assert property ($fell(deep_stop_mode) |-> ##[1:2] !wake_req)
    else $error("wake request kept after deep stop exit");
  a_reset_off: assert property ($past(rst) |-> !comparator_enable && !ref_dac_enable
    && avs_waitrequest && !edge_irq && !wake_req)
    else $error("outputs not at defaults after reset");
endmodule
`default_nettype wire

/* verif/acc_analog_model.sv */
// Behavioural comparator and reference DAC on the analog side of the block.
// Assumes input levels in steps of one sixty-fourth of the DAC reference.
`timescale 1ns/10ps
`default_nettype none
module acc_analog_model
  import acc_pkg::*;
(
  input wire logic comparator_enable,
  input wire logic [ACC_ROUTE_W-1:0] pos_route,
  input wire logic [ACC_ROUTE_W-1:0] neg_route,
  input wire logic ref_dac_enable,
  input wire logic [ACC_LEVEL_W-1:0] ref_dac_level,
  input wire logic [ACC_PIN_W-1:0] ext_input_pin_allow,
  input wire logic [6:0] ext0_v,
  input wire logic [6:0] ext1_v,
  output logic raw_compare_out
);
  logic [6:0] dac_v;
  // A blocked pad or unrouted input contributes ground, not the last value;
  // all levels are arguments so every simulator sees them in the sensitivity
  function automatic logic [6:0] pick(input logic [2:0] r, input logic [2:0] pa,
                                      input logic [6:0] e0, input logic [6:0] e1,
                                      input logic [6:0] dv);
    if (r[0] && pa[0]) return e0;
    if (r[1] && pa[1]) return e1;
    return r[2] ? dv : 7'h00;
  endfunction
  // DAC gives level plus one steps; a disabled comparator idles low
  always_comb begin
    dac_v = ref_dac_enable ? {1'b0, ref_dac_level} + 7'h01 : 7'h00;
    raw_compare_out = comparator_enable &&
      (pick(pos_route, ext_input_pin_allow, ext0_v, ext1_v, dac_v) >
       pick(neg_route, ext_input_pin_allow, ext0_v, ext1_v, dac_v));
  end
endmodule
`default_nettype wire

/* verif/tb_acc_top.sv */
// Self-checking bench for the comparator control block.
// Assumes the behavioural analog model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_acc_top;
  import acc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic raw_compare_out;
  logic deep_stop_mode = 1'b0;
  logic [6:0] ext0_v = 7'h0A;
  logic [6:0] ext1_v = 7'h00;
  logic comparator_enable;
  logic hysteresis_select;
  logic [2:0] pos_route;
  logic [2:0] neg_route;
  logic ref_dac_enable;
  logic ref_dac_source;
  logic [5:0] ref_dac_level;
  logic [2:0] ext_input_pin_allow;
  logic output_pin_enable;
  logic compare_pin_out;
  logic edge_irq;
  logic wake_req;
  logic [31:0] q;
  logic [2:0] route_exp [4] = '{3'h1, 3'h2, 3'h0, 3'h4};
  int err_total = 0;
  int checks = 0;
  acc_top acc_top_inst (.*);
  acc_analog_model acc_analog_model_inst (.*);
  always #2.5 mclk = ~mclk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask
  // One bus transfer; holds everything until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] rq);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      $display("wrong value at %0t: bus transfer timed out", $time);
      tally_and_finish();
    end
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rq;
    xfer(1'b1, a, d, 4'hF, rq);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rq;
    xfer(1'b0, a, 8'h00, 4'hF, rq);
    chk_reg(rq, exp);
  endtask
  // Expected status word with enable and irq enable set, pin off
  function automatic logic [31:0] cs(input logic f, input logic r, input logic [1:0] m);
    return {24'h0, 2'b10, f, 1'b1, r, 1'b0, m};
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(8'hB0, 32'h0);
    rd(8'hB4, 32'h0);
    rd(8'hB8, 32'h0);
    rd(8'hBC, 32'h0);
    wr(8'hB4, 8'hFF);
    rd(8'hB4, 32'h33);
    wr(8'hBC, 8'hFF);
    rd(8'hBC, 32'h07);
    wr(8'hB8, 8'hFF);
    rd(8'hB8, 32'hFF);
    wr(8'hB0, 8'h44);
    rd(8'hB0, 32'h44);
    // Unmapped index and a write without lane 0 must change nothing
    wr(8'hC0, 8'h5A);
    rd(8'hC0, 32'h0);
    xfer(1'b1, 8'hB8, 8'h00, 4'hE, q);
    rd(8'hB8, 32'hFF);
    for (int c = 0; c < 4; c++) begin
      wr(8'hB4, {2'h0, c[1:0], 2'h0, c[1:0]});
      @(posedge mclk);
      chk_reg({29'h0, pos_route}, {29'h0, route_exp[c]});
      chk_reg({29'h0, neg_route}, {29'h0, route_exp[c]});
    end
    // Ext0 against a DAC at 32 steps; level before enable, selection last
    wr(8'hBC, 8'h01);
    wr(8'hB8, 8'h1F);
    wr(8'hB8, 8'h9F);
    wr(8'hB4, 8'h03);
    for (int m = 0; m < 4; m++) begin
      wr(8'hB0, {4'h9, 2'h0, m[1:0]});
      ext0_v <= 7'h28;
      repeat (12) @(posedge mclk);
      rd(8'hB0, cs(m[0], 1'b1, m[1:0]));
      chk_bit(edge_irq, m[0]);
      chk_bit(compare_pin_out, 1'b0);
      wr(8'hB0, {4'hB, 2'h0, m[1:0]});
      rd(8'hB0, cs(m[0], 1'b1, m[1:0]));
      wr(8'hB0, {4'h9, 2'h0, m[1:0]});
      rd(8'hB0, cs(1'b0, 1'b1, m[1:0]));
      ext0_v <= 7'h0A;
      repeat (12) @(posedge mclk);
      rd(8'hB0, cs(m != 1, 1'b0, m[1:0]));
      chk_bit(edge_irq, m != 1);
    end
    // Pin output, disabled result, then deep stop and wake
    wr(8'hB0, 8'h97);
    ext0_v <= 7'h28;
    repeat (12) @(posedge mclk);
    chk_bit(compare_pin_out, 1'b1);
    wr(8'hB0, 8'h03);
    rd(8'hB0, 32'h03);
    ext0_v <= 7'h0A;
    wr(8'hB0, 8'h93);
    repeat (12) @(posedge mclk);
    wr(8'hB0, 8'h93);
    deep_stop_mode <= 1'b1;
    @(posedge mclk);
    ext0_v <= 7'h28;
    repeat (12) @(posedge mclk);
    chk_bit(wake_req, 1'b1);
    chk_bit(edge_irq, 1'b0);
    rd(8'hB0, 32'h93);
    deep_stop_mode <= 1'b0;
    repeat (12) @(posedge mclk);
    chk_bit(wake_req, 1'b0);
    rd(8'hB0, 32'hBB);
    chk_bit(edge_irq, 1'b1);
    tally_and_finish();
  end
endmodule
bind acc_top acc_top_chk acc_top_chk_inst (.*);
`default_nettype wire
